/* File: verification/testbench.sv */
// self-checking bench for the window watchdog
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %s expected %0d seen %0d", nm, exp, got); end end
module testbench;
  // time base: 0 running, 1 stuck low, 2 stuck high
  int oscMode = 0;
  int cyc = 0;
  int err_count = 0;
  int n_checks = 0;
  int faultFalls = 0;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ioRailFault = 1'b0;
  logic coreRailFault = 1'b0;
  logic timingCapPin = 1'b0;
  wire triggerInput;
  wire coreResetOut_n;
  wire faultOutput_n;
  wwd_ctrl_model i_ctrl (.clock(clock), .triggerInput(triggerInput));
  // small counts keep the run short; the sample period keeps its default of one tick
  wwd_window_watchdog #(.ACT_TICKS(2), .IGNORE_TICKS(4), .WINDOW_TICKS(8),
    .STUCK_CYCLES(16), .FALLBACK_CYCLES(4)) i_dut (.clock(clock), .rst(rst), .triggerInput(triggerInput),
    .timingCapPin(timingCapPin), .ioRailFault(ioRailFault), .coreRailFault(coreRailFault),
    .coreResetOut_n(coreResetOut_n), .faultOutput_n(faultOutput_n));
  initial forever #25 clock = ~clock;
  // capacitor time base, one tick per four clocks
  always @(negedge clock) timingCapPin <= (oscMode == 0) ? cyc[1] : (oscMode == 2);
  always @(posedge clock) cyc++;
  always @(negedge faultOutput_n) faultFalls++;
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for a fault level; a hang ends the run
  task automatic waitFault(input logic lvl, input int bound);
    int clks;
    clks = 0;
    while (faultOutput_n !== lvl) begin
      @(negedge clock);
      clks++;
      if (clks > bound) begin
        err_count++;
        print_verdict();
      end
    end
  endtask
  // rail fault drops core reset and stops the watchdog
  task automatic railReset(input bit useIo);
    @(negedge clock);
    ioRailFault = useIo;
    coreRailFault = !useIo;
    repeat (4) @(negedge clock);
    `CHK("coreResetOut_n", 1'b0, coreResetOut_n)
    `CHK("faultOutput_n", 1'b1, faultOutput_n)
    ioRailFault = 1'b0;
    coreRailFault = 1'b0;
    repeat (4) @(negedge clock);
    `CHK("coreResetOut_n", 1'b1, coreResetOut_n)
  endtask
  // trigger held low: activation, ignore, then a missed window
  task automatic sHeld();
    int t0;
    railReset(1'b0);
    t0 = cyc;
    i_ctrl.setLevel(1'b0);
    waitFault(1'b0, 100);
    `CHK("missFall", 1'b1, cyc - t0 >= 56)
    repeat (16) @(negedge clock);
    `CHK("faultOutput_n", 1'b0, faultOutput_n)
    i_ctrl.setLevel(1'b1);
  endtask
  // short low after a core reset never starts the watchdog
  task automatic sEarly();
    int f0;
    railReset(1'b1);
    f0 = faultFalls;
    i_ctrl.strobe(5);
    repeat (200) @(negedge clock);
    `CHK("faultFalls", f0, faultFalls)
  endtask
  // serviced cycles with glitches, then a closed-window trigger
  task automatic sService();
    int t0;
    int f0;
    railReset(1'b1);
    i_ctrl.strobe(16);
    repeat (9) @(negedge clock);
    f0 = faultFalls;
    for (int i = 0; i < 5; i++) begin
      // lone low sample is no trigger
      i_ctrl.strobe(1);
      repeat (9) @(negedge clock);
      i_ctrl.strobe(12);
      repeat (24) @(negedge clock);
    end
    repeat (11) @(negedge clock);
    i_ctrl.strobe(12);
    `CHK("faultFalls", f0, faultFalls)
    repeat (9) @(negedge clock);
    i_ctrl.strobe(8);
    waitFault(1'b0, 20);
    t0 = cyc;
    repeat (10) @(negedge clock);
    i_ctrl.strobe(12);
    waitFault(1'b1, 40);
    `CHK("holdLen", 1'b1, cyc - t0 >= 28 && cyc - t0 <= 34)
  endtask
  // stopped then stuck-high time base
  task automatic sStuck();
    int f0;
    railReset(1'b1);
    i_ctrl.strobe(16);
    repeat (16) @(negedge clock);
    oscMode = 1;
    repeat (24) @(negedge clock);
    f0 = faultFalls;
    repeat (4) begin
      i_ctrl.strobe(12);
      repeat (40) @(negedge clock);
    end
    `CHK("stuckFalls", 2, faultFalls - f0)
    waitFault(1'b1, 60);
    oscMode = 2;
    waitFault(1'b0, 40);
    `CHK("faultOutput_n", 1'b0, faultOutput_n)
    repeat (12) @(negedge clock);
    oscMode = 0;
  endtask
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    sHeld();
    sEarly();
    sService();
    sStuck();
    print_verdict();
  end
endmodule

/* File: verification/wwd_ctrl_model.sv */
// behavioural supervised controller on the trigger pin
`timescale 1ns/10ps
module wwd_ctrl_model (
  input wire logic clock,
  output logic triggerInput
);
  // pin idles high through the pull-up
  initial triggerInput = 1'b1;
  // level change lands just after a falling edge
  task automatic setLevel(input logic lvl);
    @(negedge clock);
    triggerInput = lvl;
  endtask
  task automatic strobe(input int lowClks);
    setLevel(1'b0);
    repeat (lowClks) @(negedge clock);
    triggerInput = 1'b1;
  endtask
endmodule

/* File: verification/wwd_properties.sv */
// port assertions for the window watchdog
`timescale 1ns/10ps
module wwd_properties #(
  parameter int ACT_TICKS = 8,
  parameter int IGNORE_TICKS = 64,
  parameter int WINDOW_TICKS = 32,
  parameter int STUCK_CYCLES = 4000
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic triggerInput,
  input wire logic timingCapPin,
  input wire logic ioRailFault,
  input wire logic coreRailFault,
  input wire logic coreResetOut_n,
  input wire logic faultOutput_n
);
  // ****************************************
  // helper counters
  // ****************************************
  // tick sync, as deep as the block's own
  logic [2:0] capSync;
  // ticks while fault is low
  int lowTicks;
  // ticks with trigger held low
  int quietTicks;
  // clocks with timing pin high
  int highRun;
  // trigger went low since release
  logic armSeen;
  wire tick = capSync[1] & ~capSync[2];
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  // any core reset restarts the watch, as it does the block
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capSync <= 3'h0;
      lowTicks <= 0;
      quietTicks <= 0;
      highRun <= 0;
      armSeen <= 1'b0;
    end else begin
      capSync <= {capSync[1:0], timingCapPin};
      lowTicks <= faultOutput_n ? 0 : lowTicks + int'(tick);
      quietTicks <= (triggerInput || !coreResetOut_n) ? 0 : quietTicks + int'(tick);
      highRun <= timingCapPin ? highRun + 1 : 0;
      armSeen <= coreResetOut_n && (armSeen || !triggerInput);
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_rail_drops_reset: assert property ((ioRailFault || coreRailFault) |-> ##3 !coreResetOut_n)
    else $error("core reset stays high");
  a_rail_ok_release: assert property ((!ioRailFault && !coreRailFault) |-> ##3 coreResetOut_n)
    else $error("core reset stays low");
  a_reset_clears_fault: assert property (!coreResetOut_n |-> ##1 faultOutput_n)
    else $error("fault held through core reset");
  a_release_idle: assert property ($fell(rst) |-> faultOutput_n && !coreResetOut_n)
    else $error("outputs wrong at release");
  a_fault_needs_arm: assert property ($fell(faultOutput_n) |-> armSeen)
    else $error("fault while never armed");
  a_hold_window: assert property ($rose(faultOutput_n) && coreResetOut_n && lowTicks > 1 |->
    lowTicks >= WINDOW_TICKS) else $error("fault hold too short");
  a_missed_window: assert property (quietTicks == ACT_TICKS + IGNORE_TICKS + WINDOW_TICKS + 3
    |-> !faultOutput_n) else $error("missed window not flagged");
  a_stuck_high_fault: assert property (highRun == STUCK_CYCLES + 8 && armSeen |-> !faultOutput_n)
    else $error("stuck timing pin not flagged");
endmodule
bind wwd_window_watchdog wwd_properties #(.ACT_TICKS(ACT_TICKS), .IGNORE_TICKS(IGNORE_TICKS),
  .WINDOW_TICKS(WINDOW_TICKS), .STUCK_CYCLES(STUCK_CYCLES)) i_props (.clock(clock), .rst(rst),
  .triggerInput(triggerInput), .timingCapPin(timingCapPin), .ioRailFault(ioRailFault),
  .coreRailFault(coreRailFault), .coreResetOut_n(coreResetOut_n), .faultOutput_n(faultOutput_n));

/* File: verilog/wwd_pkg.sv */
// constants, mode codes and state record of the window watchdog
package wwd_pkg;

  // ****************************************
  // clock and time base
  // ****************************************
  // system clock rate in hertz
  localparam int CLOCK_HZ = 20_000_000;
  // counter width for all window counters
  localparam int CNT_W = 16;
  // activation low time in time-base ticks
  localparam int ACT_TICKS = 8;
  // ignore window in time-base ticks
  localparam int IGNORE_TICKS = 64;
  // open, closed and fault-hold window in ticks
  localparam int WINDOW_TICKS = 32;
  // ticks between two trigger samples
  localparam int SAMPLE_TICKS = 1;

  // ****************************************
  // oscillator supervision
  // ****************************************
  // time without an edge before the time base counts as dead
  localparam longint STUCK_TIME_US = 200;
  // least time rounds up to whole cycles
  localparam int STUCK_CYCLES =
    int'((STUCK_TIME_US * CLOCK_HZ + 64'd999999) / 64'd1000000);
  // fallback sample period while the time base is stopped
  localparam longint FALLBACK_TIME_US = 50;
  // longest time rounds down
  localparam int FALLBACK_CYCLES = int'((FALLBACK_TIME_US * CLOCK_HZ) / 64'd1000000);

  // ****************************************
  // types
  // ****************************************
  // watchdog modes, gray along off-arm-ignore-open-closed
  typedef enum logic [2:0] {
    WWD_OFF = 3'h0,
    WWD_ARM = 3'h1,
    WWD_IGNORE = 3'h3,
    WWD_OPEN = 3'h2,
    WWD_CLOSED = 3'h6
  } wwd_mode_t;

  // complete state of the watchdog
  typedef struct packed {
    logic trigMeta;
    logic trig;
    logic oscMeta;
    logic osc;
    logic oscPrev;
    logic [1:0] railMeta;
    logic [1:0] rail;
    logic [CNT_W-1:0] stuckCnt;
    logic stuckLow;
    logic stuckHigh;
    logic [CNT_W-1:0] smpCnt;
    logic [3:0] hist;
    wwd_mode_t mode;
    logic [CNT_W-1:0] winCnt;
    logic [CNT_W-1:0] faultCnt;
    logic resetOut;
    logic faultOut;
  } wwd_state_t;

endpackage

/* File: verilog/wwd_window_watchdog.sv */
// window watchdog with core reset output and time-base supervision
// Operation
// R01 - activate on held-low trigger after reset release
// R02 - early trigger release keeps watchdog off
// R03 - controller releases trigger in ignore window
// R04 - core reset low forces watchdog off
// R05 - ignore window disregards all trigger activity
// R06 - ignore expiry enters open window, bounded
// R07 - valid trigger ends open window immediately
// R08 - closed window fixed length, then open again
// R09 - trigger sampled once per sample period
// R10 - timing derived from capacitor time base
// R11 - valid trigger: two high, two low
// R12 - trigger belongs to window of last sample
// R13 - missed open window pulls fault low
// R14 - trigger in closed window pulls fault low
// R15 - fault stays high while serviced correctly
// R16 - controller triggers inside every open window
// R17 - controller never triggers in closed window
// R18 - shorted time base faults every second trigger
// R19 - open timing pin pulls fault low
// R20 - rail fault drives core reset low
// R21 - windows are tick counts, restarted per transition
`timescale 1ns/10ps

module wwd_window_watchdog #(
  parameter int ACT_TICKS = wwd_pkg::ACT_TICKS,
  parameter int IGNORE_TICKS = wwd_pkg::IGNORE_TICKS,
  parameter int WINDOW_TICKS = wwd_pkg::WINDOW_TICKS,
  parameter int SAMPLE_TICKS = wwd_pkg::SAMPLE_TICKS,
  parameter int STUCK_CYCLES = wwd_pkg::STUCK_CYCLES,
  parameter int FALLBACK_CYCLES = wwd_pkg::FALLBACK_CYCLES
) (
  // system clock, 20 MHz
  input wire logic clock,
  // asynchronous reset, active high
  input wire logic rst,
  // trigger pin from the supervised controller
  input wire logic triggerInput,
  // level of the capacitor oscillator on the timing pin
  input wire logic timingCapPin,
  // io rail out of window, from its comparator
  input wire logic ioRailFault,
  // core rail feedback out of window
  input wire logic coreRailFault,
  // core reset, low while a rail is out of window
  output logic coreResetOut_n,
  // watchdog fault, low on invalid triggering
  output logic faultOutput_n
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // every count must fit the counters and be at least one, the stuck count at least two
  localparam int CMAX = (1 << wwd_pkg::CNT_W) - 1;
  if (ACT_TICKS < 1 || ACT_TICKS > CMAX) begin : gChkAct
    $error("activation count out of range");
  end
  if (IGNORE_TICKS < 1 || IGNORE_TICKS > CMAX) begin : gChkIgn
    $error("ignore count out of range");
  end
  if (WINDOW_TICKS < 1 || WINDOW_TICKS > CMAX) begin : gChkWin
    $error("window count out of range");
  end
  if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > CMAX) begin : gChkSmp
    $error("sample count out of range");
  end
  if (STUCK_CYCLES < 2 || STUCK_CYCLES > CMAX) begin : gChkStk
    $error("stuck count out of range");
  end
  if (FALLBACK_CYCLES < 1 || FALLBACK_CYCLES > CMAX) begin : gChkFb
    $error("fallback count out of range");
  end

  // ****************************************
  // sized terminal counts
  // ****************************************
  // last value of each counter before it wraps, or for the stuck counter where it holds
  localparam logic [wwd_pkg::CNT_W-1:0] ACT_LAST = wwd_pkg::CNT_W'(ACT_TICKS - 1);
  localparam logic [wwd_pkg::CNT_W-1:0] IGN_LAST = wwd_pkg::CNT_W'(IGNORE_TICKS - 1);
  localparam logic [wwd_pkg::CNT_W-1:0] WIN_LAST = wwd_pkg::CNT_W'(WINDOW_TICKS - 1);
  localparam logic [wwd_pkg::CNT_W-1:0] WIN_LOAD = wwd_pkg::CNT_W'(WINDOW_TICKS);
  localparam logic [wwd_pkg::CNT_W-1:0] SMP_LAST = wwd_pkg::CNT_W'(SAMPLE_TICKS - 1);
  localparam logic [wwd_pkg::CNT_W-1:0] STK_LAST = wwd_pkg::CNT_W'(STUCK_CYCLES - 1);
  localparam logic [wwd_pkg::CNT_W-1:0] FB_LAST = wwd_pkg::CNT_W'(FALLBACK_CYCLES - 1);
  localparam logic [wwd_pkg::CNT_W-1:0] CNT_ONE = wwd_pkg::CNT_W'(1);
  localparam logic [wwd_pkg::CNT_W-1:0] CNT_ZERO = '0;
  // filtered falling edge, oldest sample first
  localparam logic [3:0] EDGE_PATTERN = 4'hC;

  // ****************************************
  // state
  // ****************************************
  // registered state and its next value
  wwd_pkg::wwd_state_t st;
  wwd_pkg::wwd_state_t next_st;

  // ****************************************
  // next-state logic
  // ****************************************
  // single combinational pass over the whole state record
  always_comb begin
    // one time-base edge seen this cycle
    logic tick;
    // step of the sample counter
    logic smpStep;
    // terminal count of the sample counter
    logic [wwd_pkg::CNT_W-1:0] smpLast;
    // a sample is taken this cycle
    logic sampleEv;
    // filtered falling edge completed this cycle
    logic trigValid;
    // step of the fault-hold counter
    logic holdStep;
    // a fault pulse starts this cycle
    logic faultStart;
    next_st = st;
    tick = 1'b0;
    smpStep = 1'b0;
    smpLast = SMP_LAST;
    sampleEv = 1'b0;
    trigValid = 1'b0;
    holdStep = 1'b0;
    faultStart = 1'b0;

    // pins pass two flops before use
    next_st.trigMeta = triggerInput;
    next_st.trig = st.trigMeta;
    next_st.oscMeta = timingCapPin;
    next_st.osc = st.oscMeta;
    next_st.oscPrev = st.osc;
    next_st.railMeta = {ioRailFault, coreRailFault};
    next_st.rail = st.railMeta;

    // R20 rail fault resets core
    next_st.resetOut = ~|st.rail;

    // R10 time-base edge detect
    tick = st.osc & ~st.oscPrev;

    // oscillator supervision: any level change rearms it
    if (st.osc != st.oscPrev) begin
      next_st.stuckCnt = CNT_ZERO;
      next_st.stuckLow = 1'b0;
      next_st.stuckHigh = 1'b0;
    end else if (st.stuckCnt == STK_LAST) begin
      // stuck low means shorted pin, stuck high means open pin
      next_st.stuckLow = ~st.osc;
      next_st.stuckHigh = st.osc;
    end else begin
      next_st.stuckCnt = st.stuckCnt + CNT_ONE;
    end

    // R09 sample strobe
    // a time base stuck low would blind the filter, so fall back to the clock
    if (st.stuckLow) begin
      smpStep = 1'b1;
      smpLast = FB_LAST;
    end else begin
      smpStep = tick;
      smpLast = SMP_LAST;
    end
    if (smpStep) begin
      if (st.smpCnt >= smpLast) begin
        next_st.smpCnt = CNT_ZERO;
        sampleEv = 1'b1;
      end else begin
        next_st.smpCnt = st.smpCnt + CNT_ONE;
      end
    end

    // R11 two-high two-low filter
    if (sampleEv) begin
      next_st.hist = {st.hist[2:0], st.trig};
      trigValid = ({st.hist[2:0], st.trig} == EDGE_PATTERN);
    end

    // fault hold follows whichever sample source is live
    holdStep = st.stuckLow ? sampleEv : tick;

    // mode sequence
    unique case (st.mode)
      // R01 wait for reset release and a low trigger
      wwd_pkg::WWD_OFF: begin
        next_st.winCnt = CNT_ZERO;
        if (st.resetOut && sampleEv && !st.trig) begin
          next_st.mode = wwd_pkg::WWD_ARM;
        end
      end
      // R02 early release drops back to off
      wwd_pkg::WWD_ARM: begin
        if (sampleEv && st.trig) begin
          next_st.mode = wwd_pkg::WWD_OFF;
          next_st.winCnt = CNT_ZERO;
        end else if (tick) begin
          // R01 low held long enough
          if (st.winCnt == ACT_LAST) begin
            next_st.mode = wwd_pkg::WWD_IGNORE;
            next_st.winCnt = CNT_ZERO;
          end else begin
            next_st.winCnt = st.winCnt + CNT_ONE;
          end
        end
      end
      // R05 trigger activity not looked at here
      wwd_pkg::WWD_IGNORE: begin
        if (tick) begin
          // R06 ignore expiry opens window
          if (st.winCnt == IGN_LAST) begin
            next_st.mode = wwd_pkg::WWD_OPEN;
            next_st.winCnt = CNT_ZERO;
          end else begin
            next_st.winCnt = st.winCnt + CNT_ONE;
          end
        end
      end
      // open window waits for a filtered edge
      wwd_pkg::WWD_OPEN: begin
        if (trigValid) begin
          // R07 R12 edge ends open window
          next_st.mode = wwd_pkg::WWD_CLOSED;
          next_st.winCnt = CNT_ZERO;
        end else if (tick) begin
          if (st.winCnt == WIN_LAST) begin
            // R13 missed window faults
            faultStart = 1'b1;
            next_st.winCnt = CNT_ZERO;
          end else begin
            next_st.winCnt = st.winCnt + CNT_ONE;
          end
        end
      end
      // closed window must stay quiet
      wwd_pkg::WWD_CLOSED: begin
        if (trigValid) begin
          // R14 R18 early trigger faults, restarts open
          faultStart = 1'b1;
          next_st.mode = wwd_pkg::WWD_OPEN;
          next_st.winCnt = CNT_ZERO;
        end else if (tick) begin
          // R08 closed window expiry
          if (st.winCnt == WIN_LAST) begin
            next_st.mode = wwd_pkg::WWD_OPEN;
            next_st.winCnt = CNT_ZERO;
          end else begin
            next_st.winCnt = st.winCnt + CNT_ONE;
          end
        end
      end
      // illegal codes recover to off
      default: begin
        next_st.mode = wwd_pkg::WWD_OFF;
        next_st.winCnt = CNT_ZERO;
      end
    endcase

    // R21 fault hold counts window ticks
    if (faultStart) begin
      next_st.faultCnt = WIN_LOAD;
    end else if (holdStep && st.faultCnt != CNT_ZERO) begin
      next_st.faultCnt = st.faultCnt - CNT_ONE;
    end

    // R04 core reset clears mode, window count and fault hold
    if (!st.resetOut) begin
      next_st.mode = wwd_pkg::WWD_OFF;
      next_st.winCnt = CNT_ZERO;
      next_st.faultCnt = CNT_ZERO;
    end

    // R15 R19 fault output level
    next_st.faultOut = ~((next_st.faultCnt != CNT_ZERO) | st.stuckHigh);
  end

  // ****************************************
  // state register
  // ****************************************
  // reset holds the core in reset and the fault line high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.mode <= wwd_pkg::WWD_OFF;
      st.trig <= 1'b1;
      st.trigMeta <= 1'b1;
      st.hist <= 4'hF;
      st.faultOut <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // both outputs come straight from flops
  assign coreResetOut_n = st.resetOut;
  assign faultOutput_n = st.faultOut;

endmodule
